// ### sim/rcm_core_model.sv
`timescale 1ns/1ps
module rcm_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic boot_jump,
    input wire logic tgt_vld,
    input wire logic [31:0] tgt,
    output logic [31:0] fetch_addr
);
    // ==========
    // Fetch address
    always_ff @(posedge clk) begin
        if (rst || boot_jump) begin
            fetch_addr <= 32'h00000000;
        end else if (tgt_vld) begin
            fetch_addr <= tgt;
        end
    end
endmodule : rcm_core_model

// ### sim/rcm_top_properties.sv
`timescale 1ns/1ps
module rcm_top_properties
    import rcm_pkg::*;
#(
    parameter logic [15:0] HOLD_CYCLES = 16'h0004,
    parameter logic [15:0] KERNEL_CYCLES = 16'h0010
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_expire,
    input wire logic boot_select_pin,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_sel_flash,
    input wire logic fetch_sel_sram,
    input wire logic fetch_sel_kernel,
    input wire logic fetch_denied,
    input wire logic [31:0] fetch_mem_addr,
    input wire logic sys_reset,
    input wire logic kernel_active,
    input wire logic boot_jump
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========
    // Phase counters
    logic [15:0] hold_cnt_reg;
    logic [15:0] kern_cnt_reg;
    always_ff @(posedge clk) begin
        hold_cnt_reg <= (rst || !sys_reset) ? 16'h0000 : hold_cnt_reg + 16'h0001;
        kern_cnt_reg <= (rst || !kernel_active || sys_reset) ? 16'h0000 : kern_cnt_reg + 16'h0001;
    end
    // ==========
    // Properties
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_ready; s_setup |=> s_answer; endproperty
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    property p_slverr; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_alias;
        fetch_addr <= 32'h20 |=> (fetch_sel_flash && fetch_mem_addr == 32'h80000 + $past(fetch_addr))
            || (fetch_sel_sram && fetch_mem_addr == 32'h10000 + $past(fetch_addr));
    endproperty
    property p_rst_flash; sys_reset && fetch_addr <= 32'h20 |=> fetch_sel_flash; endproperty
    property p_hidden;
        fetch_addr inside {[32'h8F800:32'h8FFFF]} && !kernel_active |=> fetch_denied && !fetch_sel_kernel;
    endproperty
    property p_jump;
        boot_jump |-> $past(kernel_active) && !kernel_active && kern_cnt_reg >= KERNEL_CYCLES - 16'h1 ##1 !boot_jump;
    endproperty
    property p_stay; kernel_active && !boot_select_pin |=> kernel_active; endproperty
    property p_wdt; wdt_expire && !sys_reset |=> sys_reset && kernel_active; endproperty
    property p_hold; $fell(sys_reset) |-> kernel_active && hold_cnt_reg >= HOLD_CYCLES; endproperty
    a_ready: assert property (p_ready) else $error("no single pready after setup");
    a_idle: assert property (p_idle) else $error("read data not zero while idle");
    a_slverr: assert property (p_slverr) else $error("error response malformed");
    a_alias: assert property (p_alias) else $error("alias window route wrong");
    a_rst_flash: assert property (p_rst_flash) else $error("reset did not map flash");
    a_hidden: assert property (p_hidden) else $error("kernel region reachable");
    a_jump: assert property (p_jump) else $error("boot jump malformed");
    a_stay: assert property (p_stay) else $error("kernel left with boot pin low");
    a_wdt: assert property (p_wdt) else $error("watchdog did not reset");
    a_hold: assert property (p_hold) else $error("reset hold too short");
endmodule : rcm_top_properties

// ### sim/reset_cause_and_memory_remap_test.sv
`timescale 1ns/1ps
`include "rcm_defs.svh"
module reset_cause_and_memory_remap_test;
    localparam logic [31:0] AL = `RCM_ADDR_ALIAS_CTRL;
    localparam logic [31:0] CF = `RCM_ADDR_CAUSE_FLAGS;
    localparam logic [31:0] CC = `RCM_ADDR_CAUSE_CLEAR;
    localparam logic [31:0] IS = `RCM_ADDR_IRQ_STATUS;
    localparam logic [31:0] IM = `RCM_ADDR_IRQ_MASK;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, ext_reset_req, wdt_expire, tgt_vld;
    logic boot_select_pin, fetch_sel_flash, fetch_sel_sram, fetch_sel_kernel, fetch_denied;
    logic sys_reset, kernel_active, boot_jump, irq;
    logic [31:0] paddr, pwdata, prdata, fetch_addr, fetch_mem_addr, tgt, rd;
    int fails, n_tests;
    always #50 clk = ~clk;
    rcm_top #(.SMALL_FLASH(1'b1), .SMALL_SRAM(1'b0)) dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_reset_req(ext_reset_req),
        .wdt_expire(wdt_expire), .boot_select_pin(boot_select_pin), .fetch_addr(fetch_addr),
        .fetch_sel_flash(fetch_sel_flash), .fetch_sel_sram(fetch_sel_sram),
        .fetch_sel_kernel(fetch_sel_kernel), .fetch_denied(fetch_denied),
        .fetch_mem_addr(fetch_mem_addr), .sys_reset(sys_reset), .kernel_active(kernel_active),
        .boot_jump(boot_jump), .irq(irq));
    rcm_core_model core_u (.clk(clk), .rst(rst), .boot_jump(boot_jump), .tgt_vld(tgt_vld),
        .tgt(tgt), .fetch_addr(fetch_addr));
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            fails++;
            tally_and_finish();
        end
        rd = prdata;
        chk("pslverr", 32'(e), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(nm, exp, rd);
    endtask : rd_chk
    task automatic fetch(input logic [31:0] a);
        @(posedge clk);
        tgt <= a;
        tgt_vld <= 1'b1;
        @(posedge clk);
        tgt_vld <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : fetch
    task automatic wait_jump();
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if (boot_jump === 1'b1) break;
        end
        if (k == 300) begin
            fails++;
            tally_and_finish();
        end
    endtask : wait_jump
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // ==========
    // Tests
    initial begin
        {clk, rst, psel, penable, pwrite, ext_reset_req, wdt_expire, tgt_vld} = 8'h40;
        {paddr, pwdata, tgt, rd, fails, n_tests} = '0;
        boot_select_pin = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk("cause", CF, 32'h01);
        rd_chk("alias", AL, 32'h10);
        rd_chk("clear", CC, 32'h00);
        wait_jump();
        repeat (2) @(posedge clk);
        chk("vector", 32'h80000, fetch_mem_addr);
        $display("test power_on done");
        fetch(32'h00080100);
        wr(AL, 32'hFF);
        rd_chk("alias_set", AL, 32'h11);
        fetch(32'h20);
        chk("sram_alias", 32'h10020, fetch_mem_addr);
        fetch(32'h00080100);
        wr(AL, 32'h00);
        fetch(32'h20);
        chk("flash_alias", 32'h80020, fetch_mem_addr);
        fetch(32'h0008F800);
        chk("kernel_deny", 32'h1, 32'(fetch_denied));
        apb(1'b0, 32'hFFFF0238, 32'h0, 1'b1);
        chk("unmapped", 32'h0, rd);
        $display("test remap done");
        wr(CF, 32'h03);
        rd_chk("cause_ro", CF, 32'h01);
        wr(CC, 32'h07);
        rd_chk("cause_clr", CF, 32'h00);
        fetch(32'h00080100);
        wr(AL, 32'h01);
        fetch(32'h0);
        chk("sram_zero", 32'h10000, fetch_mem_addr);
        wdt_expire <= 1'b1;
        @(posedge clk);
        wdt_expire <= 1'b0;
        wait_jump();
        chk("flash_rst", 32'h80000, fetch_mem_addr);
        rd_chk("cause_wdt", CF, 32'h02);
        rd_chk("alias_rst", AL, 32'h10);
        wr(IM, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq_on", 32'h1, 32'(irq));
        wr(IM, 32'h00);
        repeat (2) @(posedge clk);
        chk("irq_mask", 32'h0, 32'(irq));
        wr(IM, 32'h01);
        rd_chk("irq_stat", IS, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'h0, 32'(irq));
        $display("test watchdog done");
        wr(CC, 32'h07);
        wr(CF, 32'h04);
        wait_jump();
        rd_chk("cause_sw", CF, 32'h04);
        wr(CC, 32'h07);
        ext_reset_req <= 1'b1;
        @(posedge clk);
        ext_reset_req <= 1'b0;
        wait_jump();
        rd_chk("cause_ext", CF, 32'h00);
        rd_chk("irq_stat2", IS, 32'h06);
        $display("test sources done");
        boot_select_pin <= 1'b0;
        wr(CF, 32'h04);
        repeat (60) @(posedge clk);
        chk("kernel_stay", 32'h1, 32'(kernel_active));
        fetch(32'h0008F800);
        chk("kernel_sel", 32'h1, 32'(fetch_sel_kernel));
        boot_select_pin <= 1'b1;
        wait_jump();
        $display("test boot_pin done");
        tally_and_finish();
    end
endmodule : reset_cause_and_memory_remap_test
bind rcm_top rcm_top_properties #(.HOLD_CYCLES(HOLD_CYCLES), .KERNEL_CYCLES(KERNEL_CYCLES)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_expire(wdt_expire), .boot_select_pin(boot_select_pin),
    .fetch_addr(fetch_addr), .fetch_sel_flash(fetch_sel_flash), .fetch_sel_sram(fetch_sel_sram),
    .fetch_sel_kernel(fetch_sel_kernel), .fetch_denied(fetch_denied),
    .fetch_mem_addr(fetch_mem_addr), .sys_reset(sys_reset), .kernel_active(kernel_active),
    .boot_jump(boot_jump));

// ### verilog/rcm_alias_decode.sv
`timescale 1ns/1ps
`include "rcm_defs.svh"
module rcm_alias_decode
    import rcm_pkg::*;
(
    input wire logic [31:0] addr,
    input wire logic remap,
    input wire logic kernel_active,
    output logic sel_flash,
    output logic sel_sram,
    output logic sel_kernel,
    output logic denied,
    output logic [31:0] mem_addr
);

    logic in_alias;
    logic in_flash;
    logic in_sram;
    logic in_kernel;

    always_comb begin
        in_alias = (addr <= `RCM_ALIAS_TOP);
        in_kernel = (addr >= `RCM_KERNEL_BASE) &&
            (addr < `RCM_KERNEL_BASE + `RCM_KERNEL_SIZE);
        in_flash = !in_kernel && (addr >= `RCM_FLASH_BASE) &&
            (addr < `RCM_FLASH_BASE + `RCM_FLASH_SIZE);
        in_sram = (addr >= `RCM_SRAM_BASE) && (addr < `RCM_SRAM_BASE + `RCM_SRAM_SIZE);
        sel_flash = 1'b0;
        sel_sram = 1'b0;
        sel_kernel = 1'b0;
        denied = 1'b0;
        mem_addr = addr;
        if (in_kernel) begin
            sel_kernel = kernel_active;
            denied = !kernel_active;
        end else if (in_alias) begin
            if (remap) begin
                sel_sram = 1'b1;
                mem_addr = `RCM_SRAM_BASE + addr;
            end else begin
                sel_flash = 1'b1;
                mem_addr = `RCM_FLASH_BASE + addr;
            end
        end else begin
            sel_flash = in_flash;
            sel_sram = in_sram;
            denied = !(in_flash || in_sram);
        end
    end

endmodule : rcm_alias_decode

// ### verilog/rcm_defs.svh
// Function
// - Vector alias window spans 0x00 to 0x20
// - Any reset maps flash at address zero
// - Alias bit set maps SRAM at zero
// - Alias bit cleared maps flash back
// - Reset enters hidden kernel, jumps if boot pin
// - Kernel region unreachable by user accesses
// - Four reset sources, cause bits accumulate until cleared
// - All-zero cause means external reset
// - Power-on sets cause bit 0, reads 0x01
// - Watchdog reset sets cause bit 1
// - Software sets bit 2, forcing reset
// - Cause bits clear by write-one clear register
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH

// ==========================================================
// Register byte addresses
`define RCM_ADDR_ALIAS_CTRL 32'hFFFF0220
`define RCM_ADDR_CAUSE_FLAGS 32'hFFFF0230
`define RCM_ADDR_CAUSE_CLEAR 32'hFFFF0234
`define RCM_ADDR_IRQ_STATUS 32'hFFFF0240
`define RCM_ADDR_IRQ_MASK 32'hFFFF0244

// ==========================================================
// Field positions
`define RCM_ALIAS_REMAP_BIT 0
`define RCM_ALIAS_SRAM_SMALL_BIT 3
`define RCM_ALIAS_FLASH_SMALL_BIT 4
`define RCM_CAUSE_POR_BIT 0
`define RCM_CAUSE_WDT_BIT 1
`define RCM_CAUSE_SW_BIT 2
`define RCM_IRQ_WDT_BIT 0
`define RCM_IRQ_SW_BIT 1
`define RCM_IRQ_EXT_BIT 2

// ==========================================================
// Reset values
`define RCM_CAUSE_RESET 3'h1
`define RCM_IRQ_RESET 3'h0

// ==========================================================
// Memory map
`define RCM_ALIAS_TOP 32'h00000020
`define RCM_FLASH_BASE 32'h00080000
`define RCM_FLASH_SIZE 32'h00010000
`define RCM_SRAM_BASE 32'h00010000
`define RCM_SRAM_SIZE 32'h00002000
`define RCM_KERNEL_BASE 32'h0008F800
`define RCM_KERNEL_SIZE 32'h00000800

// ==========================================================
// Timing counts
`define RCM_HOLD_CYCLES 16'h0004
`define RCM_KERNEL_CYCLES 16'h0010

`endif

// ### verilog/rcm_pkg.sv
package rcm_pkg;

    typedef enum logic [1:0] {
        RCM_RUN = 2'b00,
        RCM_HOLD = 2'b01,
        RCM_KERNEL = 2'b10
    } rcm_state_t;

    typedef struct packed {
        rcm_state_t state;
        logic [15:0] cnt;
        logic remap;
        logic [2:0] cause;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sys_reset;
        logic kernel_active;
        logic boot_jump;
        logic f_flash;
        logic f_sram;
        logic f_kernel;
        logic f_denied;
        logic [31:0] f_addr;
    } rcm_regs_t;

endpackage : rcm_pkg

// ### verilog/rcm_top.sv
`timescale 1ns/1ps
`include "rcm_defs.svh"
module rcm_top
    import rcm_pkg::*;
#(
    parameter logic SMALL_FLASH = 1'b0,
    parameter logic SMALL_SRAM = 1'b0,
    parameter logic [15:0] HOLD_CYCLES = `RCM_HOLD_CYCLES,
    parameter logic [15:0] KERNEL_CYCLES = `RCM_KERNEL_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_req,
    input wire logic wdt_expire,
    input wire logic boot_select_pin,
    input wire logic [31:0] fetch_addr,
    output logic fetch_sel_flash,
    output logic fetch_sel_sram,
    output logic fetch_sel_kernel,
    output logic fetch_denied,
    output logic [31:0] fetch_mem_addr,
    output logic sys_reset,
    output logic kernel_active,
    output logic boot_jump,
    output logic irq
);

    rcm_regs_t r_reg;
    rcm_regs_t r_next;
    logic d_flash;
    logic d_sram;
    logic d_kernel;
    logic d_denied;
    logic [31:0] d_addr;
    logic setup;
    logic wr_done;
    logic rd_done;
    logic sw_force;
    logic [2:0] ev;
    logic [2:0] rd_clear;
    logic [31:0] rdata;
    logic hit;

    // ==========================================================
    // Fetch alias decode
    rcm_alias_decode u_dec (
        .addr(fetch_addr),
        .remap(r_reg.remap),
        .kernel_active(r_reg.kernel_active),
        .sel_flash(d_flash),
        .sel_sram(d_sram),
        .sel_kernel(d_kernel),
        .denied(d_denied),
        .mem_addr(d_addr)
    );

    // ==========================================================
    // Next state
    always_comb begin
        r_next = r_reg;
        setup = psel && !penable;
        wr_done = psel && penable && r_reg.pready && pwrite;
        rd_done = psel && penable && r_reg.pready && !pwrite;
        sw_force = wr_done && (paddr == `RCM_ADDR_CAUSE_FLAGS) &&
            pwdata[`RCM_CAUSE_SW_BIT];
        ev = 3'h0;
        rd_clear = 3'h0;
        rdata = 32'h00000000;
        hit = 1'b1;

        // Bus read mux
        case (paddr)
            `RCM_ADDR_ALIAS_CTRL: begin
                rdata[`RCM_ALIAS_REMAP_BIT] = r_reg.remap;
                rdata[`RCM_ALIAS_SRAM_SMALL_BIT] = SMALL_SRAM;
                rdata[`RCM_ALIAS_FLASH_SMALL_BIT] = SMALL_FLASH;
            end
            `RCM_ADDR_CAUSE_FLAGS: begin
                rdata[2:0] = r_reg.cause;
            end
            `RCM_ADDR_CAUSE_CLEAR: begin
                rdata = 32'h00000000;
            end
            `RCM_ADDR_IRQ_STATUS: begin
                rdata[2:0] = r_reg.irq_stat;
            end
            `RCM_ADDR_IRQ_MASK: begin
                rdata[2:0] = r_reg.irq_mask;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // APB answer one cycle after setup
        r_next.pready = setup;
        if (setup) begin
            r_next.prdata = pwrite ? 32'h00000000 : rdata;
            r_next.pslverr = !hit;
        end else begin
            r_next.prdata = 32'h00000000;
            r_next.pslverr = 1'b0;
        end

        // Register writes
        if (wr_done) begin
            case (paddr)
                `RCM_ADDR_ALIAS_CTRL: begin
                    r_next.remap = pwdata[`RCM_ALIAS_REMAP_BIT];
                end
                `RCM_ADDR_CAUSE_CLEAR: begin
                    r_next.cause = r_reg.cause & ~pwdata[2:0];
                end
                `RCM_ADDR_IRQ_MASK: begin
                    r_next.irq_mask = pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
        if (rd_done && (paddr == `RCM_ADDR_IRQ_STATUS)) begin
            rd_clear = 3'h7;
        end

        // Reset sources
        if (r_reg.state != RCM_HOLD) begin
            if (wdt_expire) begin
                ev[`RCM_IRQ_WDT_BIT] = 1'b1;
                r_next.cause[`RCM_CAUSE_WDT_BIT] = 1'b1;
            end
            if (sw_force) begin
                ev[`RCM_IRQ_SW_BIT] = 1'b1;
                r_next.cause[`RCM_CAUSE_SW_BIT] = 1'b1;
            end
            if (ext_reset_req) begin
                ev[`RCM_IRQ_EXT_BIT] = 1'b1;
            end
        end

        // Sequencer
        r_next.boot_jump = 1'b0;
        case (r_reg.state)
            RCM_RUN: begin
                if (ev != 3'h0) begin
                    r_next.state = RCM_HOLD;
                    r_next.cnt = HOLD_CYCLES;
                    r_next.sys_reset = 1'b1;
                    r_next.remap = 1'b0;
                    r_next.kernel_active = 1'b1;
                end
            end
            RCM_HOLD: begin
                r_next.remap = 1'b0;
                if (r_reg.cnt <= 16'h0001) begin
                    r_next.state = RCM_KERNEL;
                    r_next.cnt = KERNEL_CYCLES;
                    r_next.sys_reset = 1'b0;
                end else begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end
            end
            RCM_KERNEL: begin
                if (ev != 3'h0) begin
                    r_next.state = RCM_HOLD;
                    r_next.cnt = HOLD_CYCLES;
                    r_next.sys_reset = 1'b1;
                    r_next.remap = 1'b0;
                end else if (r_reg.cnt > 16'h0001) begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end else if (boot_select_pin) begin
                    r_next.state = RCM_RUN;
                    r_next.cnt = 16'h0000;
                    r_next.kernel_active = 1'b0;
                    r_next.boot_jump = 1'b1;
                end else begin
                    r_next.cnt = 16'h0000;
                end
            end
            default: begin
                r_next.state = RCM_KERNEL;
                r_next.cnt = KERNEL_CYCLES;
            end
        endcase

        // Sticky events, set wins over read clear
        r_next.irq_stat = (r_reg.irq_stat & ~rd_clear) | ev;
        r_next.irq = |(r_next.irq_stat & r_next.irq_mask);

        // Registered fetch route
        r_next.f_flash = d_flash;
        r_next.f_sram = d_sram;
        r_next.f_kernel = d_kernel;
        r_next.f_denied = d_denied;
        r_next.f_addr = d_addr;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg.state <= RCM_KERNEL;
            r_reg.cnt <= KERNEL_CYCLES;
            r_reg.remap <= 1'b0;
            r_reg.cause <= `RCM_CAUSE_RESET;
            r_reg.irq_stat <= `RCM_IRQ_RESET;
            r_reg.irq_mask <= `RCM_IRQ_RESET;
            r_reg.irq <= 1'b0;
            r_reg.pready <= 1'b0;
            r_reg.pslverr <= 1'b0;
            r_reg.prdata <= 32'h00000000;
            r_reg.sys_reset <= 1'b0;
            r_reg.kernel_active <= 1'b1;
            r_reg.boot_jump <= 1'b0;
            r_reg.f_flash <= 1'b0;
            r_reg.f_sram <= 1'b0;
            r_reg.f_kernel <= 1'b0;
            r_reg.f_denied <= 1'b0;
            r_reg.f_addr <= 32'h00000000;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign fetch_sel_flash = r_reg.f_flash;
    assign fetch_sel_sram = r_reg.f_sram;
    assign fetch_sel_kernel = r_reg.f_kernel;
    assign fetch_denied = r_reg.f_denied;
    assign fetch_mem_addr = r_reg.f_addr;
    assign sys_reset = r_reg.sys_reset;
    assign kernel_active = r_reg.kernel_active;
    assign boot_jump = r_reg.boot_jump;
    assign irq = r_reg.irq;

endmodule : rcm_top
